// >>> pkg/spm_cfg.svh
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

// Reset values of the control bits
`define SPM_RST_SELECT_MODE 2'h1
`define SPM_RST_ENABLE      1'h0
`define SPM_RST_MASTER      1'h0
`define SPM_RST_PHASE       1'h0
`define SPM_RST_POLARITY    1'h0
`define SPM_RST_RATE        8'h00

// Select mode encodings
`define SPM_MODE_3WIRE      2'h0
`define SPM_MODE_4WIRE_IN   2'h1

// Byte framing
`define SPM_LAST_BIT        3'h7
`define SPM_LAST_HALF       4'hF

`endif

// >>> pkg/spm_pkg.sv
package spm_pkg;

  typedef enum logic [1:0] {
    SPM_MST_IDLE = 2'b01,
    SPM_MST_RUN  = 2'b10
  } spm_mst_e;

  typedef struct packed {
    logic       port_enable;
    logic       master_enable;
    logic [1:0] select_mode;
    logic       clock_phase;
    logic       clock_polarity;
  } spm_ctl_s;

  typedef struct packed {
    logic xfer_done_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic rx_overrun_flag;
  } spm_flags_s;

  typedef struct packed {
    logic busy;
    logic tx_empty;
    logic rx_full;
    logic shift_empty;
  } spm_status_s;

  typedef struct packed {
    spm_ctl_s   ctl;
    spm_flags_s flags;
    spm_mst_e   mst;
    logic [7:0] shift;
    logic [7:0] txbuf;
    logic [7:0] rxbuf;
    logic       tx_full;
    logic       rx_full;
    logic       sr_full;
    logic [2:0] cnt;
    logic       skip;
    logic       in_bit;
    logic       prev_sck;
    logic       prev_nss;
    logic [7:0] div;
    logic [3:0] half;
    logic       sck;
  } spm_state_s;

endpackage

// >>> rtl/spm_serial_port.sv
`timescale 1ns/1ps
`include "spm_cfg.svh"
module spm_serial_port (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                ctl_wr,
  input  wire spm_pkg::spm_ctl_s   ctl_wdata,
  input  wire logic [7:0]          clock_rate_reg,
  input  wire logic                dat_wr,
  input  wire logic [7:0]          dat_wdata,
  input  wire logic                dat_rd,
  input  wire spm_pkg::spm_flags_s flag_clr,
  input  wire logic                irq_enable,
  output spm_pkg::spm_ctl_s        ctl_q,
  output spm_pkg::spm_flags_s      flags_q,
  output spm_pkg::spm_status_s     status_q,
  output logic [7:0]               port_data_reg,
  output logic                     irq,
  input  wire logic                sck_i,
  output logic                     sck_o,
  output logic                     sck_oe,
  input  wire logic                mosi_i,
  output logic                     mosi_o,
  output logic                     mosi_oe,
  input  wire logic                miso_i,
  output logic                     miso_o,
  output logic                     miso_oe,
  input  wire logic                nss_i,
  output logic                     nss_o,
  output logic                     nss_oe
);
  import spm_pkg::*;

  spm_state_s st_ff;
  spm_state_s nxt_st;
  logic       is_master;
  logic       selected;
  logic       eff_sck;
  logic       lead_edge;
  logic       trail_edge;
  logic       samp;
  logic       shft;
  logic       din;
  logic       nss_fall;
  logic       fault;
  logic       done;
  logic       load;

  always_comb
  begin
    is_master = st_ff.ctl.port_enable & st_ff.ctl.master_enable;
    selected  = (st_ff.ctl.select_mode == `SPM_MODE_3WIRE) |
                ((st_ff.ctl.select_mode == `SPM_MODE_4WIRE_IN) & ~nss_i);
    eff_sck    = is_master ? st_ff.sck : sck_i;
    // edge roles from polarity and phase
    lead_edge  = (st_ff.prev_sck == st_ff.ctl.clock_polarity) &
                 (eff_sck != st_ff.ctl.clock_polarity);
    trail_edge = (st_ff.prev_sck != st_ff.ctl.clock_polarity) &
                 (eff_sck == st_ff.ctl.clock_polarity);
    samp = st_ff.ctl.port_enable & (is_master | selected) &
           (st_ff.ctl.clock_phase ? trail_edge : lead_edge);
    shft = st_ff.ctl.port_enable & (is_master | selected) &
           (st_ff.ctl.clock_phase ? lead_edge : trail_edge);
    din      = is_master ? miso_i : mosi_i;
    nss_fall = st_ff.prev_nss & ~nss_i;
    fault = is_master & (st_ff.ctl.select_mode == `SPM_MODE_4WIRE_IN) & ~nss_i;
    done  = st_ff.ctl.port_enable & ~fault & samp & (st_ff.cnt == `SPM_LAST_BIT);
    load  = st_ff.ctl.port_enable & ~fault & ~st_ff.sr_full & st_ff.tx_full &
            (is_master ? (st_ff.mst == SPM_MST_IDLE) & ~st_ff.skip : 1'b1);
  end

  always_comb
  begin
    nxt_st = st_ff;
    if (ctl_wr)
    begin
      nxt_st.ctl = ctl_wdata;
    end
    nxt_st.flags = st_ff.flags & ~flag_clr;
    if (dat_rd)
    begin
      nxt_st.rx_full = 1'b0;
    end
    if (dat_wr)
    begin
      if (st_ff.tx_full)
      begin
        nxt_st.flags.write_collision_flag = 1'b1;
      end
      else
      begin
        nxt_st.txbuf   = dat_wdata;
        nxt_st.tx_full = 1'b1;
      end
    end
    nxt_st.prev_sck = eff_sck;
    nxt_st.prev_nss = nss_i;
    if (!st_ff.ctl.port_enable)
    begin
      nxt_st.cnt     = 3'h0;
      nxt_st.sr_full = 1'b0;
      nxt_st.skip    = 1'b0;
      nxt_st.mst     = SPM_MST_IDLE;
      nxt_st.sck     = st_ff.ctl.clock_polarity;
      nxt_st.div     = 8'h00;
      nxt_st.half    = 4'h0;
    end
    else if (fault)
    begin
      nxt_st.ctl.port_enable           = 1'b0;
      nxt_st.ctl.master_enable         = 1'b0;
      nxt_st.flags.mode_fault_flag     = 1'b1;
      nxt_st.mst                       = SPM_MST_IDLE;
      nxt_st.sck                       = st_ff.ctl.clock_polarity;
      nxt_st.cnt                       = 3'h0;
      nxt_st.sr_full                   = 1'b0;
      nxt_st.skip                      = 1'b0;
    end
    else
    begin
      // half period is rate plus one clocks
      case (st_ff.mst)
        SPM_MST_RUN:
        begin
          if (!is_master)
          begin
            nxt_st.mst = SPM_MST_IDLE;
            nxt_st.sck = st_ff.ctl.clock_polarity;
          end
          else if (st_ff.div == clock_rate_reg)
          begin
            nxt_st.div  = 8'h00;
            nxt_st.sck  = ~st_ff.sck;
            nxt_st.half = st_ff.half + 4'h1;
            if (st_ff.half == `SPM_LAST_HALF)
            begin
              nxt_st.mst = SPM_MST_IDLE;
            end
          end
          else
          begin
            nxt_st.div = st_ff.div + 8'h01;
          end
        end
        default:
        begin
          nxt_st.sck = st_ff.ctl.clock_polarity;
        end
      endcase
      if (!is_master && st_ff.ctl.select_mode == `SPM_MODE_4WIRE_IN && nss_fall)
      begin
        nxt_st.cnt  = 3'h0;
        nxt_st.skip = st_ff.ctl.clock_phase;
      end
      else if (samp)
      begin
        nxt_st.in_bit = din;
        nxt_st.cnt    = st_ff.cnt + 3'h1;
        if (done)
        begin
          nxt_st.flags.xfer_done_flag = 1'b1;
          nxt_st.sr_full              = 1'b0;
          nxt_st.skip                 = ~st_ff.ctl.clock_phase;
          if (!is_master && st_ff.rx_full)
          begin
            nxt_st.flags.rx_overrun_flag = 1'b1;
          end
          else
          begin
            nxt_st.rxbuf   = {st_ff.shift[6:0], din};
            nxt_st.rx_full = 1'b1;
          end
        end
      end
      if (shft)
      begin
        if (st_ff.skip)
        begin
          nxt_st.skip = 1'b0;
        end
        else
        begin
          nxt_st.shift = {st_ff.shift[6:0], st_ff.in_bit};
        end
      end
      if (load)
      begin
        nxt_st.shift   = st_ff.txbuf;
        nxt_st.sr_full = 1'b1;
        nxt_st.tx_full = 1'b0;
        if (st_ff.cnt == 3'h0)
        begin
          // A pending last-edge skip must survive the reload
          nxt_st.skip = st_ff.ctl.clock_phase | nxt_st.skip;
        end
        // only a master starts a transfer
        if (is_master)
        begin
          nxt_st.mst  = SPM_MST_RUN;
          nxt_st.div  = 8'h00;
          nxt_st.half = 4'h0;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      nxt_st_reset();
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  task automatic nxt_st_reset();
    st_ff                    <= '0;
    st_ff.ctl.select_mode    <= `SPM_RST_SELECT_MODE;
    st_ff.ctl.port_enable    <= `SPM_RST_ENABLE;
    st_ff.ctl.master_enable  <= `SPM_RST_MASTER;
    st_ff.ctl.clock_phase    <= `SPM_RST_PHASE;
    st_ff.ctl.clock_polarity <= `SPM_RST_POLARITY;
    st_ff.mst                <= SPM_MST_IDLE;
    st_ff.prev_nss           <= 1'b1;
  endtask

  // Pin drivers; data comes straight from flops, enables are decoded
  always_comb
  begin
    ctl_q                = st_ff.ctl;
    flags_q              = st_ff.flags;
    status_q.busy        = (st_ff.cnt != 3'h0) | (st_ff.mst == SPM_MST_RUN);
    status_q.tx_empty    = ~st_ff.tx_full;
    status_q.rx_full     = st_ff.rx_full;
    status_q.shift_empty = ~st_ff.sr_full;
    port_data_reg        = st_ff.rxbuf;
    irq    = irq_enable & (|st_ff.flags);
    sck_o  = st_ff.sck;
    sck_oe = is_master;
    mosi_o  = st_ff.shift[7];
    mosi_oe = is_master;
    miso_o  = st_ff.shift[7];
    // MISO released unless a selected slave
    miso_oe = st_ff.ctl.port_enable & ~st_ff.ctl.master_enable & selected;
    // NSS output level from low mode bit
    nss_o  = st_ff.ctl.select_mode[0];
    nss_oe = st_ff.ctl.port_enable & st_ff.ctl.select_mode[1];
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_collision_drop:
    assert property (dat_wr && st_ff.tx_full |=>
                     flags_q.write_collision_flag && $stable(st_ff.txbuf))
      else $error("collision write was not dropped");

  a_fault_disable:
    assert property (fault |=> !ctl_q.port_enable && !ctl_q.master_enable &&
                     flags_q.mode_fault_flag && !sck_oe)
      else $error("mode fault did not disable the port");

  a_done_flag:
    assert property (done |=> flags_q.xfer_done_flag && status_q.shift_empty)
      else $error("byte end did not raise done");

  a_overrun_keep:
    assert property (done && !is_master && st_ff.rx_full |=>
                     $stable(port_data_reg) && flags_q.rx_overrun_flag)
      else $error("overrun replaced the held byte");

  a_nss_fall_cnt:
    assert property (st_ff.ctl.port_enable && !is_master && !fault &&
                     ctl_q.select_mode == `SPM_MODE_4WIRE_IN && nss_fall |=>
                     st_ff.cnt == 3'h0)
      else $error("falling select did not clear the counter");

  a_disabled_hold:
    assert property (!ctl_q.port_enable |-> (!miso_oe && !mosi_oe) ##1
                     (st_ff.cnt == 3'h0 && st_ff.mst == SPM_MST_IDLE))
      else $error("disabled port still active");

  a_master_start:
    assert property (load && is_master |=> st_ff.mst == SPM_MST_RUN ##0
                     mosi_o == $past(st_ff.txbuf[7]))
      else $error("master did not start after load");

  a_slave_no_start:
    assert property (!ctl_q.master_enable && !$past(ctl_q.master_enable) |->
                     st_ff.mst == SPM_MST_IDLE)
      else $error("slave started a transfer");

  a_sck_rate:
    assert property (st_ff.mst == SPM_MST_RUN && $changed(st_ff.sck) |->
                     $past(st_ff.div) == clock_rate_reg)
      else $error("master clock toggled off rate");

  a_miso_release:
    assert property (!ctl_q.port_enable ||
                     (ctl_q.select_mode == `SPM_MODE_4WIRE_IN && nss_i) |-> !miso_oe)
      else $error("MISO driven while it must be released");

  c_master_byte:
    cover property (done && is_master);
  c_slave_byte:
    cover property (done && !is_master);
  c_mode_fault:
    cover property (fault);
  c_collision:
    cover property (dat_wr && st_ff.tx_full);

endmodule

// >>> bench/spm_slave_model.sv
`timescale 1ns/1ps
module spm_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       nss,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh = 8'h00;
  logic       hold = 1'h0;
  initial rx_byte = 8'h00;
  always @(negedge nss) sh = tx_byte;
  always @(posedge sck) if (!nss) rx_byte = {rx_byte[6:0], mosi};
  always @(negedge sck) if (!nss) sh = {sh[6:0], 1'h0};
  // Released line shows a stale inverse so a missed sample is seen
  always @(posedge nss) hold = ~sh[7];
  assign miso = nss ? hold : sh[7];
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
  import spm_pkg::*;
  logic        clk = 0, srst = 1, ctl_wr = 0, dat_wr = 0, dat_rd = 0, irq_enable = 1;
  logic [7:0]  rate = 8'h01, dat_wdata = 8'h00, s_rx, got, pdr;
  logic        t_sck = 0, t_mosi = 0, t_nss = 1, irq, miso_p;
  logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, nss_o, nss_oe;
  spm_ctl_s    ctl_wdata = '0, ctl_q;
  spm_flags_s  flag_clr = '0, flags_q;
  spm_status_s status_q;
  int          error_cnt = 0, samples_checked = 0;
  wire logic   sck = sck_oe ? sck_o : t_sck;
  wire logic   mosi = mosi_oe ? mosi_o : t_mosi;
  wire logic   miso = miso_oe ? miso_o : miso_p;
  wire logic   nss = nss_oe ? nss_o : t_nss;
  always #10 clk = ~clk;
  spm_serial_port i_dut (.clk, .srst, .ctl_wr, .ctl_wdata, .clock_rate_reg(rate), .dat_wr,
    .dat_wdata, .dat_rd, .flag_clr, .irq_enable, .ctl_q, .flags_q, .status_q,
    .port_data_reg(pdr), .irq, .sck_i(sck), .sck_o, .sck_oe, .mosi_i(mosi), .mosi_o,
    .mosi_oe, .miso_i(miso), .miso_o, .miso_oe, .nss_i(nss), .nss_o, .nss_oe);
  spm_slave_model i_peer (.sck(sck), .mosi(mosi), .nss(nss), .tx_byte(8'h3C), .miso(miso_p),
    .rx_byte(s_rx));
  task chk(input string n, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task setc(input logic [5:0] v);
    ctl_wdata = v;
    ctl_wr = 1;
    step(1);
    ctl_wr = 0;
  endtask
  task clr(input logic rd);
    flag_clr = 4'hF;
    dat_rd = rd;
    step(1);
    flag_clr = '0;
    dat_rd = 0;
  endtask
  task wr(input logic [7:0] d);
    dat_wdata = d;
    dat_wr = 1;
    step(1);
    dat_wr = 0;
  endtask
  // Second write rides the same strobe, one clock after the first
  task wr2(input logic [7:0] a, input logic [7:0] b);
    dat_wdata = a;
    dat_wr = 1;
    step(1);
    dat_wdata = b;
    step(1);
    dat_wr = 0;
  endtask
  task wait_done;
    for (int i = 0; i < 400 && flags_q.xfer_done_flag !== 1'h1; i++) step(1);
  endtask
  // Far-side master, phase 0: data set up, then rising sample edge
  task sbyte(input logic [7:0] d, input int nb);
    for (int i = 0; i < nb; i++)
    begin
      t_mosi = d[7-i];
      step(4);
      t_sck = 1;
      got = {got[6:0], miso};
      step(4);
      t_sck = 0;
    end
    step(4);
  endtask
  task t_master;
    int n;
    setc(6'h38);
    step(1);
    chk("nss_o", 8'h00, nss_o);
    chk("nss_oe", 8'h01, nss_oe);
    wr2(8'hA5, 8'h11);
    chk("shift_empty", 8'h00, status_q.shift_empty);
    step(2);
    chk("write_collision_flag", 8'h01, flags_q.write_collision_flag);
    wr(8'h96);
    chk("tx_empty", 8'h00, status_q.tx_empty);
    for (n = 0; n < 50 && sck_o !== 1'h0; n++) step(1);
    for (n = 0; n < 50 && sck_o !== 1'h1; n++) step(1);
    for (n = 0; n < 50 && sck_o === 1'h1; n++) step(1);
    chk("sck_high", 8'h02, n[7:0]);
    wait_done;
    chk("peer_rx", 8'hA5, s_rx);
    chk("rx_buf", 8'h3C, pdr);
    chk("irq", 8'h01, irq);
    irq_enable = 0;
    step(1);
    chk("irq_off", 8'h00, irq);
    irq_enable = 1;
    clr(1);
    wait_done;
    chk("peer_rx2", 8'h96, s_rx);
    chk("rx_buf2", 8'h00, pdr);
    setc(6'h0C);
    step(1);
    chk("nss_o_hi", 8'h01, nss_o);
    chk("miso_oe_off", 8'h00, miso_oe);
    clr(1);
  endtask
  task t_fault;
    setc(6'h34);
    step(2);
    chk("no_fault", 8'h00, flags_q.mode_fault_flag);
    t_nss = 0;
    step(3);
    chk("fault", 8'h01, flags_q.mode_fault_flag);
    chk("enables", 8'h00, {ctl_q.port_enable, ctl_q.master_enable});
    t_nss = 1;
    step(2);
    // software turns the port back on
    setc(6'h34);
    chk("reenable", 8'h01, ctl_q.master_enable);
    step(1);
    setc(6'h00);
    clr(1);
  endtask
  task t_slave4;
    setc(6'h24);
    wr(8'h5A);
    step(2);
    chk("miso_oe_unsel", 8'h00, miso_oe);
    sbyte(8'hFF, 8);
    chk("unsel_done", 8'h00, flags_q.xfer_done_flag);
    t_nss = 0;
    // select six clocks ahead of the first edge
    step(2);
    chk("miso_oe_sel", 8'h01, miso_oe);
    chk("no_start", 8'h00, status_q.busy);
    sbyte(8'hC3, 8);
    chk("slave_tx", 8'h5A, got);
    chk("slave_rx", 8'hC3, pdr);
    chk("slave_done", 8'h01, flags_q.xfer_done_flag);
    chk("slave_rx_full", 8'h01, status_q.rx_full);
    clr(0);
    sbyte(8'h0F, 3);
    t_nss = 1;
    step(2);
    t_nss = 0;
    step(2);
    sbyte(8'h81, 5);
    chk("cnt_reset", 8'h00, flags_q.xfer_done_flag);
    sbyte(8'h20, 3);
    chk("ovr_done", 8'h01, flags_q.xfer_done_flag);
    chk("ovr_keep", 8'hC3, pdr);
    chk("ovr_flag", 8'h01, flags_q.rx_overrun_flag);
    t_nss = 1;
    setc(6'h00);
    clr(1);
  endtask
  task t_slave3;
    setc(6'h20);
    chk("miso_oe_3w", 8'h01, miso_oe);
    wr(8'hE7);
    step(2);
    sbyte(8'h3D, 8);
    chk("tx_3w", 8'hE7, got);
    chk("rx_3w", 8'h3D, pdr);
    clr(1);
    sbyte(8'h00, 3);
    t_nss = 0;
    step(2);
    t_nss = 1;
    sbyte(8'h00, 5);
    chk("nss_ignored", 8'h01, flags_q.xfer_done_flag);
    clr(1);
    sbyte(8'h00, 3);
    setc(6'h00);
    chk("off_miso", 8'h00, miso_oe);
    step(1);
    setc(6'h20);
    sbyte(8'h81, 8);
    chk("reen_rx", 8'h81, pdr);
  endtask
  // Far-side master, phase 1 idle-high: falling edge shifts, rising edge samples
  task sbyte_p1(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
    begin
      t_sck = 0;
      t_mosi = d[7-i];
      step(4);
      t_sck = 1;
      got = {got[6:0], miso};
      step(4);
    end
    step(4);
  endtask
  task t_slave_p1;
    clr(1);
    setc(6'h03);
    // Clock parked high while the port is off and while it is idle
    t_sck = 1;
    step(2);
    chk("sck_idle", 8'h01, sck_o);
    setc(6'h23);
    wr(8'hB4);
    step(2);
    sbyte_p1(8'h6D);
    chk("tx_p1", 8'hB4, got);
    chk("rx_p1", 8'h6D, pdr);
    chk("done_p1", 8'h01, flags_q.xfer_done_flag);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #200us;
    error_cnt++;
    wrap_up;
  end
  initial
  begin
    step(3);
    srst = 0;
    step(1);
    chk("mode_rst", 8'h01, ctl_q.select_mode);
    chk("miso_rst", 8'h00, miso_oe);
    t_master;
    t_fault;
    t_slave4;
    t_slave3;
    t_slave_p1;
    wrap_up;
  end
endmodule
